/* hdl/fsss_pkg.sv */
package fsss_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned FSSS_CLK_NS = 4;
   localparam int unsigned FSSS_MS_NS = 1_000_000;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [5:0] OFF_SRC1 = 6'h00;
   localparam logic [5:0] OFF_SRC2 = 6'h04;
   localparam logic [5:0] OFF_KP1 = 6'h08;
   localparam logic [5:0] OFF_KP2 = 6'h0C;
   localparam logic [5:0] OFF_UPPER = 6'h10;
   localparam logic [5:0] OFF_STEP = 6'h14;
   localparam logic [5:0] OFF_MBREL = 6'h18;
   localparam logic [5:0] OFF_MBABS = 6'h1C;
   localparam logic [5:0] OFF_SET1 = 6'h20;
   localparam logic [5:0] OFF_SET2 = 6'h24;
   localparam logic [5:0] OFF_STAT = 6'h28;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [7:0] SRC1_RST = 8'h02;
   localparam logic [7:0] SRC2_RST = 8'h00;
   localparam logic [15:0] UPPER_RST = 16'h1388;
   localparam logic [15:0] STEP_RST = 16'h000A;
   localparam logic signed [31:0] REL_FULL = 32'h0000_2710;
   localparam logic signed [31:0] ABS_FULL = 32'h0000_7530;
   localparam logic signed [31:0] F_MAX = 32'h0000_7FFF;
   localparam logic signed [31:0] F_MIN = 32'hFFFF_8000;

   // ---------------------------------------------------------------
   // Source codes
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      SRC_KP_KEEP = 8'h00, SRC_KP_STOPZ = 8'h01, SRC_KP_NV = 8'h02,
      SRC_WHEEL = 8'h03, SRC_UD_VOL = 8'h04, SRC_UD_STOPZ = 8'h05,
      SRC_UD_NV = 8'h06, SRC_UD_BI = 8'h07, SRC_UD_BINV = 8'h08,
      SRC_AN1 = 8'h09, SRC_AN2 = 8'h0A, SRC_AN3 = 8'h0B,
      SRC_AN1_BI = 8'h0C, SRC_AN3_BI = 8'h0D, SRC_PULSE = 8'h0E,
      SRC_PULSE_BI = 8'h0F, SRC_MB_REL = 8'h10, SRC_MB_ABS = 8'h11,
      SRC_A1_A2 = 8'h12, SRC_A2_A3 = 8'h13, SRC_A2_PUL = 8'h14,
      SRC_A1_MUL = 8'h15, SRC_A1_DIV = 8'h16, SRC_PID_PROC = 8'h17,
      SRC_PID_COMP = 8'h18, SRC_DISTURB = 8'h19
   } fsss_src_t;

endpackage : fsss_pkg

/* hdl/fsss_top.sv */
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module fsss_top
   import fsss_pkg::*;
#(
   parameter int unsigned MS_CYC = FSSS_MS_NS / FSSS_CLK_NS
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic increment_terminal,
   input wire logic decrement_terminal,
   input wire logic clear_terminal,
   input wire logic forward_command,
   input wire logic reverse_command,
   input wire logic panel_key_up,
   input wire logic panel_key_down,
   input wire logic power_fail,
   input wire logic drive_running,
   input wire logic [15:0] wheel_value,
   input wire logic [15:0] first_analog_input,
   input wire logic [15:0] second_analog_input,
   input wire logic [15:0] third_analog_input,
   input wire logic [15:0] second_analog_full,
   input wire logic [15:0] pulse_freq,
   input wire logic [15:0] pid_process_out,
   input wire logic [15:0] pid_comp_out,
   input wire logic [15:0] disturb_freq,
   input wire logic nv_valid,
   input wire logic [31:0] nv_keypad_value,
   input wire logic [31:0] nv_step_value,
   output logic [15:0] set_value_one,
   output logic [15:0] set_value_two,
   output logic run_reverse_one,
   output logic run_reverse_two,
   output logic nv_save,
   output logic [31:0] nv_keypad_save,
   output logic [31:0] nv_step_save
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic signed [31:0] clip(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clip

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [7:0] pin_raw;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] sync3_q;

   assign pin_raw = {power_fail, panel_key_down, panel_key_up,
                     reverse_command, forward_command, clear_terminal,
                     decrement_terminal, increment_terminal};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_sync
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
               sync3_q[g] <= 1'b0;
            end else begin
               sync1_q[g] <= pin_raw[g];
               sync2_q[g] <= sync1_q[g];
               sync3_q[g] <= sync2_q[g];
            end
         end
      end
   endgenerate

   logic up_on, dn_on, clr_on, reverse_req, key_up, key_dn, pf_rise;
   assign up_on = sync2_q[0];
   assign dn_on = sync2_q[1];
   assign clr_on = sync2_q[2];
   assign reverse_req = sync2_q[4] & ~sync2_q[3];
   assign key_up = sync2_q[5] & ~sync3_q[5];
   assign key_dn = sync2_q[6] & ~sync3_q[6];
   assign pf_rise = sync2_q[7] & ~sync3_q[7];

   // ---------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------
   logic wait_q;
   logic [31:0] rdata_q;
   logic wr_go;
   logic [7:0] src_q [2];
   logic signed [15:0] kp_q [2];
   logic signed [15:0] step_q [2];
   logic signed [15:0] setv_q [2];
   logic dir_q [2];
   logic [15:0] upper_q, step_ms_q;
   logic signed [15:0] mb_rel_q, mb_abs_q;
   logic run_prev_q, loaded_q;

   assign wr_go = avs_write & ~wait_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(wait_q & (avs_read | avs_write));
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read & wait_q) begin
         case (avs_address)
            OFF_SRC1: rdata_q <= {24'h00_0000, src_q[0]};
            OFF_SRC2: rdata_q <= {24'h00_0000, src_q[1]};
            OFF_KP1: rdata_q <= {16'h0000, kp_q[0]};
            OFF_KP2: rdata_q <= {16'h0000, kp_q[1]};
            OFF_UPPER: rdata_q <= {16'h0000, upper_q};
            OFF_STEP: rdata_q <= {16'h0000, step_ms_q};
            OFF_MBREL: rdata_q <= {16'h0000, mb_rel_q};
            OFF_MBABS: rdata_q <= {16'h0000, mb_abs_q};
            OFF_SET1: rdata_q <= {16'h0000, setv_q[0]};
            OFF_SET2: rdata_q <= {16'h0000, setv_q[1]};
            OFF_STAT: rdata_q <= {29'h0000_0000, dir_q[1], dir_q[0],
                                  run_prev_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         upper_q <= UPPER_RST;
         step_ms_q <= STEP_RST;
         mb_rel_q <= '0;
         mb_abs_q <= '0;
      end else if (wr_go) begin
         case (avs_address)
            OFF_UPPER: upper_q <= merge16(upper_q, avs_writedata,
                                          avs_byteenable);
            OFF_STEP: step_ms_q <= merge16(step_ms_q, avs_writedata,
                                           avs_byteenable);
            OFF_MBREL: mb_rel_q <= merge16(mb_rel_q, avs_writedata,
                                           avs_byteenable);
            OFF_MBABS: mb_abs_q <= merge16(mb_abs_q, avs_writedata,
                                           avs_byteenable);
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Step interval timer and drive stop detect
   // ---------------------------------------------------------------
   logic [17:0] ms_cnt_q;
   logic [15:0] step_cnt_q;
   logic step_tick;

   assign step_tick = (ms_cnt_q == 18'(MS_CYC - 1))
                      && (step_cnt_q >= step_ms_q - 16'h0001);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt_q <= '0;
         step_cnt_q <= '0;
      end else if (ms_cnt_q == 18'(MS_CYC - 1)) begin
         ms_cnt_q <= '0;
         step_cnt_q <= step_tick ? 16'h0000 : step_cnt_q + 16'h0001;
      end else begin
         ms_cnt_q <= ms_cnt_q + 18'h0_0001;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run_prev_q <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         run_prev_q <= drive_running;
         loaded_q <= 1'b1;
      end
   end

   logic stopped;
   assign stopped = run_prev_q & ~drive_running;

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   logic signed [31:0] up32, a1, a2, a3, pu;
   assign up32 = 32'(signed'(upper_q));
   assign a1 = 32'(signed'(first_analog_input));
   assign a2 = 32'(signed'(second_analog_input));
   assign a3 = 32'(signed'(third_analog_input));
   assign pu = 32'(signed'(pulse_freq));

   generate
      for (g = 0; g < 2; g++) begin : g_ch
         logic [5:0] src_off, kp_off;
         logic is_ud, is_bi;
         logic signed [31:0] lo, kp32, st32, v, full;

         assign src_off = g ? OFF_SRC2 : OFF_SRC1;
         assign kp_off = g ? OFF_KP2 : OFF_KP1;
         assign is_ud = src_q[g] >= SRC_UD_VOL && src_q[g] <= SRC_UD_BINV;
         assign is_bi = src_q[g] == SRC_UD_BI || src_q[g] == SRC_UD_BINV;
         assign lo = is_bi ? -up32 : 32'h0000_0000;
         assign kp32 = 32'(kp_q[g]);
         assign st32 = 32'(step_q[g]);
         assign full = 32'(signed'(second_analog_full));

         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               src_q[g] <= g ? SRC2_RST : SRC1_RST;
            end else if (wr_go && avs_address == src_off
                         && avs_byteenable[0]) begin
               src_q[g] <= avs_writedata[7:0];
            end
         end

         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               kp_q[g] <= '0;
            end else if (!loaded_q) begin
               if (nv_valid && src_q[g] == SRC_KP_NV) begin
                  kp_q[g] <= nv_keypad_value[g*16 +: 16];
               end
            end else if (wr_go && avs_address == kp_off) begin
               kp_q[g] <= merge16(kp_q[g], avs_writedata, avs_byteenable);
            end else if (stopped && src_q[g] == SRC_KP_STOPZ) begin
               kp_q[g] <= '0;
            end else if (src_q[g] <= SRC_KP_NV) begin
               if (key_up && !key_dn) begin
                  kp_q[g] <= 16'(clip(kp32 + 32'sd1, 32'sd0, up32));
               end else if (key_dn && !key_up) begin
                  kp_q[g] <= 16'(clip(kp32 - 32'sd1, 32'sd0, up32));
               end
            end
         end

         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               step_q[g] <= '0;
            end else if (!loaded_q) begin
               if (nv_valid && (src_q[g] == SRC_UD_NV
                                || src_q[g] == SRC_UD_BINV)) begin
                  step_q[g] <= nv_step_value[g*16 +: 16];
               end
            end else if (is_ud) begin
               if (clr_on) begin
                  step_q[g] <= '0;
               end else if (stopped && src_q[g] == SRC_UD_STOPZ) begin
                  step_q[g] <= '0;
               end else if (step_tick && up_on && !dn_on) begin
                  step_q[g] <= 16'(clip(st32 + 32'sd1, lo, up32));
               end else if (step_tick && dn_on && !up_on) begin
                  step_q[g] <= 16'(clip(st32 - 32'sd1, lo, up32));
               end
            end
         end

         always_comb begin
            v = 32'h0000_0000;
            case (src_q[g])
               SRC_KP_KEEP, SRC_KP_STOPZ, SRC_KP_NV: v = kp32;
               SRC_WHEEL: v = 32'(signed'(wheel_value));
               SRC_UD_VOL, SRC_UD_STOPZ, SRC_UD_NV,
               SRC_UD_BI, SRC_UD_BINV: v = st32;
               SRC_AN1: v = (a1 < 0) ? 32'sd0 : a1;
               SRC_AN2: v = (a2 < 0) ? 32'sd0 : a2;
               SRC_AN3: v = (a3 < 0) ? 32'sd0 : a3;
               SRC_AN1_BI: v = a1;
               SRC_AN3_BI: v = a3;
               SRC_PULSE: v = (pu < 0) ? 32'sd0 : pu;
               SRC_PULSE_BI: v = pu;
               SRC_MB_REL: v = clip(32'(mb_rel_q), -REL_FULL, REL_FULL)
                               * up32 / REL_FULL;
               SRC_MB_ABS: v = clip(32'(mb_abs_q), -ABS_FULL,
                                    ABS_FULL);
               SRC_A1_A2: v = a1 + a2;
               SRC_A2_A3: v = a2 + a3;
               SRC_A2_PUL: v = a2 + pu;
               SRC_A1_MUL: v = (full == 0) ? 32'sd0
                                           : a1 * a2 / full;
               SRC_A1_DIV: v = (a2 == 0) ? 32'sd0
                                         : a1 * up32 / a2;
               SRC_PID_PROC: v = 32'(signed'(pid_process_out));
               SRC_PID_COMP: v = 32'(signed'(pid_comp_out));
               SRC_DISTURB: v = 32'(signed'(disturb_freq));
               default: v = 32'h0000_0000;
            endcase
         end

         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               setv_q[g] <= '0;
               dir_q[g] <= 1'b0;
            end else begin
               setv_q[g] <= 16'(clip(v, F_MIN, F_MAX));
               dir_q[g] <= reverse_req ^ v[31];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Power-loss save
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nv_save <= 1'b0;
         nv_keypad_save <= 32'h0000_0000;
         nv_step_save <= 32'h0000_0000;
      end else begin
         nv_save <= pf_rise;
         if (pf_rise) begin
            nv_keypad_save <= {kp_q[1], kp_q[0]};
            nv_step_save <= {step_q[1], step_q[0]};
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   assign set_value_one = setv_q[0];
   assign set_value_two = setv_q[1];
   assign run_reverse_one = dir_q[0];
   assign run_reverse_two = dir_q[1];

endmodule : fsss_top

/* testbench/fsss_chk.sv */
`timescale 1ns/1ps
module fsss_chk
   import fsss_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic clear_terminal,
   input wire logic forward_command,
   input wire logic reverse_command,
   input wire logic power_fail,
   input wire logic [15:0] first_analog_input,
   input wire logic [15:0] set_value_one,
   input wire logic run_reverse_one,
   input wire logic nv_save
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [7:0] src1_q;
   logic step_src;
   // -------------------------------------------------------------
   // Channel one source shadow
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         src1_q <= SRC1_RST;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
            && avs_address == OFF_SRC1) begin
         src1_q <= avs_writedata[7:0];
      end
   end
   assign step_src = src1_q >= 8'h04 && src1_q <= 8'h08;
   sequence s_req_seen;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_clear_held;
      (clear_terminal && step_src) [*6];
   endsequence
   sequence s_forward_held;
      (forward_command && !reverse_command) [*4];
   endsequence
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   a_wait_one: assert property (s_req_seen |=> !avs_waitrequest)
      else $error("access not answered");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   a_reset_idle: assert property ($rose(arst_n) |-> avs_waitrequest && !nv_save)
      else $error("bad state after reset");
   a_src_read: assert property (avs_read && !avs_waitrequest
      && avs_address == OFF_SRC1 |-> avs_readdata == {24'h00_0000, src1_q})
      else $error("source readback wrong");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address > OFF_STAT |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_clear_zero: assert property (s_clear_held |-> set_value_one == 16'h0000)
      else $error("clear did not zero");
   a_an1_follow: assert property ((src1_q == 8'h09 &&
      !first_analog_input[15] && $stable(first_analog_input)) [*2]
      |-> set_value_one == first_analog_input)
      else $error("analog one not followed");
   a_dir_sign: assert property (s_forward_held ##0 $stable(set_value_one) [*3]
      |-> run_reverse_one == set_value_one[15])
      else $error("direction not sign");
   a_pf_save: assert property ($rose(power_fail) |-> ##[1:4] nv_save)
      else $error("no save pulse");
   a_save_once: assert property (nv_save |=> !nv_save)
      else $error("save pulse too long");
endmodule : fsss_chk

bind fsss_top fsss_chk u_fsss_chk (.mclk, .arst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .clear_terminal, .forward_command, .reverse_command,
   .power_fail, .first_analog_input, .set_value_one, .run_reverse_one,
   .nv_save);

/* testbench/fsss_panel_model.sv */
`timescale 1ns/1ps
module fsss_panel_model (
   input wire logic mclk,
   output logic increment_terminal,
   output logic decrement_terminal,
   output logic clear_terminal,
   output logic forward_command,
   output logic reverse_command,
   output logic panel_key_up,
   output logic panel_key_down,
   output logic power_fail,
   output logic [15:0] wheel_value
);
   initial begin
      {power_fail, panel_key_down, panel_key_up, reverse_command} = 4'h0;
      {forward_command, clear_terminal} = 2'h0;
      {decrement_terminal, increment_terminal} = 2'h0;
      wheel_value = 16'h0037;
   end
   // Pins move only just after a clock edge
   task automatic set_pins(input logic [7:0] p);
      @(posedge mclk);
      {power_fail, panel_key_down, panel_key_up, reverse_command,
         forward_command, clear_terminal, decrement_terminal,
         increment_terminal} <= p;
   endtask : set_pins
endmodule : fsss_panel_model

/* testbench/fsss_top_test.sv */
`timescale 1ns/1ps
module fsss_top_test;
   import fsss_pkg::*;
   logic mclk, arst_n, avs_read, avs_write, drive_running, nv_valid;
   logic avs_waitrequest, run_reverse_one, run_reverse_two, nv_save;
   logic increment_terminal, decrement_terminal, clear_terminal;
   logic forward_command, reverse_command, panel_key_up, panel_key_down;
   logic power_fail;
   logic [5:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, nv_keypad_value, nv_step_value;
   logic [31:0] nv_keypad_save, nv_step_save;
   logic [15:0] wheel_value, first_analog_input, second_analog_input;
   logic [15:0] third_analog_input, second_analog_full, pulse_freq;
   logic [15:0] pid_process_out, pid_comp_out, disturb_freq, v, v0;
   logic [15:0] set_value_one, set_value_two;
   int errors, samples_checked, cycles;
   logic [23:0] tab [20] = '{24'h03_0037, 24'h09_03E8, 24'h0A_07D0,
      24'h0B_0BB8, 24'h0C_03E8, 24'h0D_0BB8, 24'h0E_0190, 24'h0F_0190,
      24'h10_09C4, 24'h11_05DC, 24'h12_0BB8, 24'h13_1388, 24'h14_0960,
      24'h15_01F4, 24'h16_09C4, 24'h17_006F, 24'h18_00DE, 24'h19_014D,
      24'h1A_0000, 24'h1D_0000};

   fsss_top #(.MS_CYC(4)) u_fsss_top (.mclk, .arst_n, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .increment_terminal, .decrement_terminal,
      .clear_terminal, .forward_command, .reverse_command, .panel_key_up,
      .panel_key_down, .power_fail, .drive_running, .wheel_value,
      .first_analog_input, .second_analog_input, .third_analog_input,
      .second_analog_full, .pulse_freq, .pid_process_out, .pid_comp_out,
      .disturb_freq, .nv_valid, .nv_keypad_value, .nv_step_value,
      .set_value_one, .set_value_two, .run_reverse_one, .run_reverse_two,
      .nv_save, .nv_keypad_save, .nv_step_save);
   fsss_panel_model u_fsss_panel_model (.mclk, .increment_terminal,
      .decrement_terminal, .clear_terminal, .forward_command,
      .reverse_command, .panel_key_up, .panel_key_down, .power_fail,
      .wheel_value);

   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic wrap_up();
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
      end
   endtask : chk_reg
   task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t out got %h exp %h", $time, g, e);
      end
   endtask : chk_out
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] r;
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      chk_reg(r, e);
   endtask : rd_chk
   task automatic try_src(input logic [7:0] c, input logic [15:0] e);
      wr(OFF_SRC1, {24'h00_0000, c});
      wr(OFF_SRC2, {24'h00_0000, c});
      repeat (3) @(posedge mclk);
      chk_out(set_value_one, e);
      chk_out(set_value_two, e);
   endtask : try_src
   task automatic hold(input logic [7:0] p, input int n);
      u_fsss_panel_model.set_pins(p);
      repeat (n) @(posedge mclk);
      v = set_value_one;
   endtask : hold
   task automatic pf_pulse();
      int i;
      u_fsss_panel_model.set_pins(8'h80);
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (nv_save !== 1'b1 && i < 10);
      chk_out({15'h0000, nv_save}, 16'h0001);
      u_fsss_panel_model.set_pins(8'h00);
   endtask : pf_pulse
   task automatic drive(input logic r);
      @(posedge mclk);
      drive_running <= r;
      repeat (4) @(posedge mclk);
   endtask : drive
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      {mclk, arst_n, avs_read, avs_write, nv_valid} = 5'h00;
      {avs_address, avs_writedata, avs_byteenable} = {6'h00, 32'h0, 4'hF};
      {nv_keypad_value, nv_step_value} = 64'h0;
      drive_running = 1'b1;
      {first_analog_input, second_analog_input} = 32'h03E8_07D0;
      {third_analog_input, second_analog_full} = 32'h0BB8_0FA0;
      {pulse_freq, pid_process_out} = 32'h0190_006F;
      {pid_comp_out, disturb_freq} = 32'h00DE_014D;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd_chk(OFF_SRC1, 32'h0000_0002);
      rd_chk(OFF_SRC2, 32'h0000_0000);
      rd_chk(OFF_UPPER, 32'h0000_1388);
      wr(6'h2C, 32'h0000_00FF);
      rd_chk(6'h2C, 32'h0000_0000);
      wr(OFF_MBREL, 32'h0000_1388);
      wr(OFF_MBABS, 32'h0000_05DC);
      for (int i = 0; i < 20; i++) try_src(tab[i][23:16], tab[i][15:0]);
      first_analog_input <= 16'hFC18;
      try_src(8'h09, 16'h0000);
      try_src(8'h0C, 16'hFC18);
      second_analog_input <= 16'h0000;
      try_src(8'h16, 16'h0000);
      {first_analog_input, second_analog_input} <= 32'h7000_7000;
      try_src(8'h12, 16'h7FFF);
      wr(OFF_STEP, 32'h0000_0001);
      wr(OFF_SRC1, 32'h0000_0004);
      hold(8'h01, 40);
      chk_out({15'h0000, v >= 16'h0008 && v <= 16'h000B}, 16'h0001);
      hold(8'h00, 8);
      v0 = v;
      hold(8'h03, 20);
      chk_out(set_value_one, v0);
      hold(8'h07, 8);
      chk_out(set_value_one, 16'h0000);
      hold(8'h02, 20);
      chk_out(set_value_one, 16'h0000);
      wr(OFF_SRC1, 32'h0000_0007);
      hold(8'h0A, 40);
      chk_out({15'h0000, v[15]}, 16'h0001);
      chk_out({15'h0000, run_reverse_one}, 16'h0001);
      chk_out({15'h0000, run_reverse_two}, 16'h0000);
      hold(8'h12, 8);
      chk_out({15'h0000, run_reverse_one}, 16'h0000);
      chk_out({15'h0000, run_reverse_two}, 16'h0001);
      wr(OFF_UPPER, 32'h0000_0003);
      wr(OFF_SRC1, 32'h0000_0004);
      hold(8'h04, 8);
      hold(8'h01, 60);
      chk_out(set_value_one, 16'h0003);
      wr(OFF_UPPER, 32'h0000_1388);
      wr(OFF_SRC1, 32'h0000_0005);
      hold(8'h01, 20);
      hold(8'h00, 4);
      drive(1'b0);
      chk_out(set_value_one, 16'h0000);
      drive(1'b1);
      wr(OFF_SRC1, 32'h0000_0000);
      wr(OFF_KP1, 32'h0000_012C);
      hold(8'h20, 4);
      hold(8'h00, 4);
      chk_out(set_value_one, 16'h012D);
      hold(8'h40, 4);
      hold(8'h00, 4);
      chk_out(set_value_one, 16'h012C);
      wr(OFF_SRC1, 32'h0000_0001);
      drive(1'b0);
      chk_out(set_value_one, 16'h0000);
      drive(1'b1);
      wr(OFF_SRC1, 32'h0000_0006);
      hold(8'h01, 20);
      hold(8'h00, 4);
      pf_pulse();
      chk_out(nv_step_save[15:0], v);
      wr(OFF_SRC1, 32'h0000_0002);
      wr(OFF_KP1, 32'h0000_01C2);
      hold(8'h00, 4);
      pf_pulse();
      chk_out(nv_keypad_save[15:0], 16'h01C2);
      @(posedge mclk);
      nv_valid <= 1'b1;
      nv_keypad_value <= 32'h0000_0309;
      arst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk_out(set_value_one, 16'h0309);
      wrap_up();
   end
endmodule : fsss_top_test
